// ### hdl/wsi_defs.vh
// Shared constants for the wake-up and status logic
`ifndef WSI_DEFS_VH
`define WSI_DEFS_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define WSI_ADDR_TXPWR 5'h07
`define WSI_ADDR_STATUS 5'h10

// ----------------------------------------------------------------------
// Transmit-power configuration layout
// ----------------------------------------------------------------------
`define WSI_TXPWR_RESET 7'h50
`define WSI_STEP_RESET 5'h10
`define WSI_TXPWR_FE_BIT 6
`define WSI_TXPWR_SEL_BIT 5
`define WSI_TXPWR_STEP_MSB 4
`define WSI_TXPWR_STEP_LSB 0

// ----------------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------------
`define WSI_ST_BUTTON_BIT 0
`define WSI_ST_POWER_BIT 1
`define WSI_ST_RAMLOSS_BIT 2
`define WSI_ST_PAD 5'h00
`define WSI_RD_NONE 8'h00

// ----------------------------------------------------------------------
// Debounce length in data-clock periods
// ----------------------------------------------------------------------
`define WSI_DEBOUNCE_PERIODS 8195
`define WSI_DEBOUNCE_WIDTH 14

// ----------------------------------------------------------------------
// Mode states
// ----------------------------------------------------------------------
`define WSI_ST_OFF 2'h0
`define WSI_ST_WAKE_BTN 2'h1
`define WSI_ST_WAKE_PWR 2'h2
`define WSI_ST_ACTIVE 2'h3

`endif

// ### hdl/wsi_sync_edge.v
// Two-stage synchronisers with edge detection for asynchronous inputs
`default_nettype none

module wsi_sync_edge #(
  parameter WIDTH = 5
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gSync
      reg stage1;
      reg stage2;
      reg stage3;
      // ------------------------------------------------------------------
      // Stage 1 feeds only stage 2; stage 3 keeps the previous level
      // ------------------------------------------------------------------
      always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
          stage3 <= 1'b0;
        end else begin
          stage1 <= asyncIn[i];
          stage2 <= stage1;
          stage3 <= stage2;
        end
      end
      assign level[i] = stage2;
      assign rise[i] = stage2 & ~stage3;
      assign fall[i] = ~stage2 & stage3;
    end
  endgenerate

endmodule // wsi_sync_edge

`default_nettype wire

// ### hdl/wsi_wakeup_status.v
// Wake-up sequencing, status flags, interrupt and TX power configuration
`include "wsi_defs.vh"
`default_nettype none

module wsi_wakeup_status #(
  parameter DEBOUNCE_PERIODS = `WSI_DEBOUNCE_PERIODS,
  parameter CNT_WIDTH = `WSI_DEBOUNCE_WIDTH
) (
  input wire clk_sys,
  input wire reset_n,
  input wire buttonWakePin,
  input wire powerWakePin,
  input wire dataClk,
  input wire supplyLow,
  input wire oscSettled,
  input wire txMode,
  input wire fdMode,
  input wire [4:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire deleteIrqCmd,
  input wire offCmd,
  output reg [7:0] regRdData,
  output reg irq,
  output reg supplyEnable,
  output reg activeMode,
  output wire clockOutEnable,
  output wire clockOnForce,
  output reg useFixedResistor,
  output reg resistorActive,
  output reg [4:0] powerStep,
  output reg frontEndBit,
  output reg resistorSelect
);

  localparam [CNT_WIDTH-1:0] DEB_TARGET = DEBOUNCE_PERIODS[CNT_WIDTH-1:0];
  localparam [CNT_WIDTH-1:0] DEB_ZERO = {CNT_WIDTH{1'b0}};
  localparam [CNT_WIDTH-1:0] DEB_ONE = {{(CNT_WIDTH-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  wire [4:0] syncLevel;
  wire [4:0] syncRise;
  wire [4:0] syncFall;

  wsi_sync_edge #(
    .WIDTH(5)
  ) uSync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .asyncIn({oscSettled, supplyLow, dataClk, powerWakePin, buttonWakePin}),
    .level(syncLevel),
    .rise(syncRise),
    .fall(syncFall)
  );

  wire buttonLevel = syncLevel[0];
  wire buttonEdge = syncRise[0] | syncFall[0];
  wire buttonFall = syncFall[0];
  wire powerLevel = syncLevel[1];
  wire powerRise = syncRise[1];
  wire dataClkRise = syncRise[2];
  wire supplyLowLevel = syncLevel[3];
  wire oscReady = syncLevel[4];

  // ----------------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------------
  reg [1:0] mode;
  reg [1:0] next_mode;
  reg [6:0] txPowerConfig;
  reg buttonFlag;
  reg powerFlag;
  reg ramLossFlag;
  reg clkOutEnable;
  reg debRunning;
  reg [CNT_WIDTH-1:0] debCount;

  wire statusRead = regRead && (regAddr == `WSI_ADDR_STATUS);
  wire txPowerRead = regRead && (regAddr == `WSI_ADDR_TXPWR);
  wire txPowerWrite = regWrite && (regAddr == `WSI_ADDR_TXPWR);
  wire supplyReady = ~supplyLowLevel & oscReady;
  wire isActive = (mode == `WSI_ST_ACTIVE);
  wire offAllowed = offCmd && isActive && ~powerLevel && buttonLevel;

  wire [7:0] statusByte = {`WSI_ST_PAD, ramLossFlag, powerFlag, buttonFlag};

  // ----------------------------------------------------------------------
  // Wake-up sequencing
  // ----------------------------------------------------------------------
  always @* begin
    next_mode = mode;
    case (mode)
      `WSI_ST_OFF: begin
        if (buttonFall) begin
          next_mode = `WSI_ST_WAKE_BTN;
        end else if (powerRise) begin
          next_mode = `WSI_ST_WAKE_PWR;
        end
      end
      `WSI_ST_WAKE_BTN: begin
        if (buttonLevel) begin
          next_mode = `WSI_ST_OFF;
        end else if (supplyReady) begin
          next_mode = `WSI_ST_ACTIVE;
        end
      end
      `WSI_ST_WAKE_PWR: begin
        if (~powerLevel) begin
          next_mode = `WSI_ST_OFF;
        end else if (supplyReady) begin
          next_mode = `WSI_ST_ACTIVE;
        end
      end
      `WSI_ST_ACTIVE: begin
        // Pin levels alone never leave the active state
        if (offAllowed) begin
          next_mode = `WSI_ST_OFF;
        end
      end
      default: begin
        next_mode = `WSI_ST_OFF;
      end
    endcase
  end

  wire wakeDone = (mode != `WSI_ST_ACTIVE) &&
                  (next_mode == `WSI_ST_ACTIVE);
  wire wakeByButton = wakeDone && (mode == `WSI_ST_WAKE_BTN);
  wire wakeByPower = wakeDone && (mode == `WSI_ST_WAKE_PWR);

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode <= `WSI_ST_OFF;
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Debounce counter on data-clock periods
  // ----------------------------------------------------------------------
  wire debReach = debRunning && dataClkRise &&
                  ((debCount + DEB_ONE) == DEB_TARGET);

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      debRunning <= 1'b0;
      debCount <= DEB_ZERO;
    end else if (!isActive || offAllowed) begin
      debRunning <= 1'b0;
      debCount <= DEB_ZERO;
    end else if (buttonEdge) begin
      if (debRunning) begin
        debRunning <= 1'b0;
      end else begin
        debRunning <= 1'b1;
      end
      debCount <= DEB_ZERO;
    end else if (debReach) begin
      debRunning <= 1'b0;
      debCount <= DEB_TARGET;
    end else if (debRunning && dataClkRise) begin
      debCount <= debCount + DEB_ONE;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  wire powerSet = wakeByPower || (isActive && powerRise);
  wire ramLossSet = wakeDone || supplyLowLevel;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      buttonFlag <= 1'b0;
    end else if (wakeByButton || debReach) begin
      buttonFlag <= ~buttonLevel;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      powerFlag <= 1'b0;
    end else if (powerSet) begin
      powerFlag <= 1'b1;
    end else if (statusRead) begin
      powerFlag <= 1'b0;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ramLossFlag <= 1'b0;
    end else if (wakeDone) begin
      ramLossFlag <= 1'b1;
    end else if (supplyLowLevel) begin
      ramLossFlag <= 1'b1;
    end else if (statusRead) begin
      ramLossFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------------
  wire powerIrqEvent = isActive && powerRise && ~powerFlag;
  wire irqSet = wakeDone || debReach || powerIrqEvent;
  wire irqClear = statusRead || deleteIrqCmd;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else if (irqSet) begin
      // A new event outweighs a clear in the same cycle
      irq <= 1'b1;
    end else if (irqClear) begin
      irq <= 1'b0;
    end else if (next_mode == `WSI_ST_OFF) begin
      irq <= 1'b0;
    end
  end

  // Held as a level until cleared; deleting drives it low

  // ----------------------------------------------------------------------
  // Clock output and supply control
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clkOutEnable <= 1'b0;
    end else if (wakeDone) begin
      clkOutEnable <= 1'b1;
    end else if (offAllowed) begin
      clkOutEnable <= 1'b0;
    end
  end

  assign clockOnForce = powerFlag | debRunning;
  assign clockOutEnable = clkOutEnable | clockOnForce;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      supplyEnable <= 1'b0;
      activeMode <= 1'b0;
    end else begin
      supplyEnable <= (next_mode != `WSI_ST_OFF);
      activeMode <= (next_mode == `WSI_ST_ACTIVE);
    end
  end

  // ----------------------------------------------------------------------
  // Transmit-power configuration register
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txPowerConfig <= `WSI_TXPWR_RESET;
    end else if (txPowerWrite) begin
      txPowerConfig <= regWrData[6:0];
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      useFixedResistor <= 1'b0;
      resistorActive <= 1'b0;
      powerStep <= `WSI_STEP_RESET;
      frontEndBit <= 1'b1;
      resistorSelect <= 1'b0;
    end else begin
      // Fixed resistor only in plain TX with select low
      useFixedResistor <= txMode & ~fdMode &
                          ~txPowerConfig[`WSI_TXPWR_SEL_BIT];
      resistorActive <= fdMode |
                        (txMode & txPowerConfig[`WSI_TXPWR_SEL_BIT]);
      powerStep <= txPowerConfig[`WSI_TXPWR_STEP_MSB:`WSI_TXPWR_STEP_LSB];
      frontEndBit <= txPowerConfig[`WSI_TXPWR_FE_BIT];
      resistorSelect <= txPowerConfig[`WSI_TXPWR_SEL_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= `WSI_RD_NONE;
    end else if (statusRead) begin
      regRdData <= statusByte;
    end else if (txPowerRead) begin
      regRdData <= {1'b0, txPowerConfig};
    end else if (regRead) begin
      regRdData <= `WSI_RD_NONE;
    end
  end

endmodule // wsi_wakeup_status

`default_nettype wire

// ### dv/wsi_wakeup_status_checker.sv
// Assertion checker for the wake-up and status block
`include "wsi_defs.vh"
`default_nettype none

module wsi_wakeup_status_checker #(
  parameter DEBOUNCE_PERIODS = 8195
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic buttonWakePin,
  input wire logic txMode,
  input wire logic fdMode,
  input wire logic [4:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic deleteIrqCmd,
  input wire logic offCmd,
  input wire logic [7:0] regRdData,
  input wire logic irq,
  input wire logic activeMode,
  input wire logic clockOutEnable,
  input wire logic clockOnForce,
  input wire logic useFixedResistor,
  input wire logic resistorActive,
  input wire logic [4:0] powerStep,
  input wire logic frontEndBit,
  input wire logic resistorSelect
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire logic rdSt = regRead && regAddr == `WSI_ADDR_STATUS;
  wire logic rdCfg = regRead && regAddr == `WSI_ADDR_TXPWR;

  AST_IRQ_HOLD: assert property (irq && !regRead && !deleteIrqCmd
    && !offCmd |=> irq) else $error("irq dropped without a clear");
  AST_DEL_IRQ: assert property (deleteIrqCmd |=> !irq)
    else $error("irq still high after delete command");
  AST_RD_CLEAR: assert property (rdSt |=> !irq)
    else $error("irq still high after status read");
  AST_ST_PAD: assert property (rdSt |=> regRdData[7:3] == 5'h00)
    else $error("status upper bits not zero");
  AST_RD_CFG: assert property (rdCfg && !regWrite |=>
    regRdData == {1'b0, frontEndBit, resistorSelect, powerStep})
    else $error("config read back differs from outputs");
  AST_UNMAPPED: assert property (regRead && !rdSt && !rdCfg
    |=> regRdData == 8'h00) else $error("unmapped read not zero");
  AST_FIXED: assert property ($past(reset_n) |-> useFixedResistor ==
    ($past(txMode && !fdMode) && !resistorSelect))
    else $error("fixed resistor choice wrong");
  AST_RES_ACT: assert property ($past(reset_n) |-> resistorActive ==
    ($past(fdMode) || ($past(txMode) && resistorSelect)))
    else $error("power step resistor use wrong");
  AST_CLK_FORCE: assert property (activeMode && $changed(buttonWakePin)
    && !clockOnForce |-> ##[2:4] clockOnForce)
    else $error("debounce did not force clock output");
  AST_OFF_CMD: assert property ($fell(activeMode) |->
    $past(offCmd) || $past(offCmd, 2)) else $error("left active w/o cmd");
  AST_WAKE_IRQ: assert property ($rose(activeMode) |-> ##[0:1] irq)
    else $error("wake without interrupt");

  cover property ($rose(activeMode));
  cover property ($fell(clockOnForce) ##[1:3] irq);
  cover property (deleteIrqCmd && irq);
endmodule // wsi_wakeup_status_checker

bind wsi_wakeup_status wsi_wakeup_status_checker #(
  .DEBOUNCE_PERIODS(DEBOUNCE_PERIODS)
) checker_i (.clk_sys, .reset_n, .buttonWakePin, .txMode, .fdMode, .regAddr,
  .regRead,
  .regWrite, .deleteIrqCmd, .offCmd, .regRdData, .irq, .activeMode,
  .clockOutEnable, .clockOnForce, .useFixedResistor, .resistorActive,
  .powerStep, .frontEndBit, .resistorSelect);
`default_nettype wire

// ### dv/wsi_host_model.sv
// Host side model issuing register accesses and serial commands
`default_nettype none

module wsi_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] regRdData,
  output logic [4:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead,
  output logic deleteIrqCmd,
  output logic offCmd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lastRd;

  initial begin
    {regAddr, regWrData, regWrite, regRead, deleteIrqCmd, offCmd} = '0;
  end

  // Kind 0 read, 1 write, 2 delete interrupt, 3 off; one-cycle strobe
  task automatic op(input logic [1:0] k, input logic [4:0] a,
    input logic [7:0] d);
    regAddr = a;
    regWrData = (k == 2'd1) ? (d | 8'h40) : d;
    {offCmd, deleteIrqCmd, regWrite, regRead} = 4'b0001 << k;
    @(posedge clk_sys);
    #1;
    lastRd = regRdData;
    {offCmd, deleteIrqCmd, regWrite, regRead} = 4'h0;
    // Released bus shows inverted values, never stale ones
    regAddr = ~a;
    regWrData = ~d;
    // Idle cycle so a following call never re-raises a strobe at once
    @(posedge clk_sys);
    #1;
  endtask
endmodule // wsi_host_model
`default_nettype wire

// ### dv/wsi_wakeup_status_test.sv
// Self-checking testbench for the wake-up and status block
`default_nettype none

module wsi_wakeup_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, reset_n = 0, dataClk = 0, btn = 1, pwr = 0;
  logic supplyLow = 0, oscSettled = 0, txMode = 0, fdMode = 0;
  logic irq, activeMode, cOut, cForce, useFixed, resAct, feBit, sel;
  logic [4:0] regAddr, powerStep;
  logic [7:0] regWrData, regRdData, d;
  logic regWrite, regRead, delCmd, offCmd, supEn;
  integer mismatches = 0, cmp_count = 0, seed, i;

  initial forever #20 clk_sys = ~clk_sys;
  initial forever #160 dataClk = ~dataClk;

  wsi_wakeup_status #(.DEBOUNCE_PERIODS(5)) uut (.clk_sys, .reset_n,
    .buttonWakePin(btn), .powerWakePin(pwr), .dataClk, .supplyLow,
    .oscSettled, .txMode, .fdMode, .regAddr, .regWrData, .regWrite,
    .regRead, .deleteIrqCmd(delCmd), .offCmd, .regRdData, .irq,
    .supplyEnable(supEn), .activeMode, .clockOutEnable(cOut),
    .clockOnForce(cForce), .useFixedResistor(useFixed),
    .resistorActive(resAct), .powerStep, .frontEndBit(feBit),
    .resistorSelect(sel));
  wsi_host_model h (.clk_sys, .regRdData, .regAddr, .regWrData,
    .regWrite, .regRead, .deleteIrqCmd(delCmd), .offCmd);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic waitIrq;
    for (int k = 0; k < 40 && irq !== 1'b1; k++) cyc(1);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [7:0] cfgExp(input logic [7:0] w);
    return {2'b01, w[5:0]};
  endfunction
  function automatic logic [7:0] resExp(input logic s, t, f);
    return {6'h00, t & ~f & ~s, f | (t & s)};
  endfunction

  initial begin
    cyc(5000);
    mismatches++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'h5aa0;
    cyc(10);
    reset_n = 1;
    chk({3'h0, powerStep}, 8'h10);
    chk({7'h00, feBit}, 8'h01);
    h.op(0, 5'h07, 0);
    chk(h.lastRd, 8'h50);
    h.op(0, 5'h03, 0);
    chk(h.lastRd, 8'h00);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      d[5] = i[0];
      if (i < 2) d[4:0] = i ? 5'h1f : 5'h00;
      h.op(1, 5'h07, d);
      {txMode, fdMode} = i[2:1];
      cyc(2);
      chk({3'h0, powerStep}, {3'h0, d[4:0]});
      chk({useFixed, resAct}, resExp(d[5], txMode, fdMode));
      h.op(0, 5'h07, 0);
      chk(h.lastRd, cfgExp(d));
    end
    btn = 0;
    cyc(8);
    chk({7'h00, supEn}, 8'h01);
    btn = 1;
    cyc(8);
    chk({activeMode, irq}, 8'h00);
    chk({7'h00, supEn}, 8'h00);
    pwr = 1;
    cyc(8);
    chk({7'h00, supEn}, 8'h01);
    pwr = 0;
    cyc(8);
    chk({activeMode, irq, supEn}, 8'h00);
    oscSettled = 1;
    pwr = 1;
    waitIrq();
    chk({activeMode, irq, cOut}, 8'h07);
    h.op(0, 5'h10, 0);
    chk(h.lastRd, 8'h06);
    chk({7'h00, irq}, 8'h00);
    h.op(0, 5'h10, 0);
    chk(h.lastRd, 8'h00);
    pwr = 0;
    cyc(5);
    pwr = 1;
    cyc(6);
    chk({irq, cOut}, 8'h03);
    h.op(2, 5'h00, 0);
    chk({7'h00, irq}, 8'h00);
    pwr = 0;
    cyc(5);
    pwr = 1;
    cyc(6);
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, cForce}, 8'h01);
    h.op(0, 5'h10, 0);
    chk(h.lastRd, 8'h02);
    pwr = 0;
    btn = 0;
    cyc(8);
    chk({7'h00, cForce}, 8'h01);
    btn = 1;
    cyc(80);
    chk({6'h00, irq, cForce}, 8'h00);
    btn = 0;
    cyc(24);
    chk({7'h00, irq}, 8'h00);
    cyc(56);
    chk({6'h00, irq, activeMode}, 8'h03);
    supplyLow = 1;
    cyc(6);
    h.op(0, 5'h10, 0);
    chk(h.lastRd, 8'h05);
    supplyLow = 0;
    cyc(6);
    h.op(0, 5'h10, 0);
    chk(h.lastRd, 8'h05);
    h.op(0, 5'h10, 0);
    chk(h.lastRd, 8'h01);
    btn = 1;
    cyc(80);
    chk({7'h00, activeMode}, 8'h01);
    h.op(3, 5'h00, 0);
    cyc(3);
    chk({activeMode, irq}, 8'h00);
    btn = 0;
    waitIrq();
    chk({activeMode, irq, cOut}, 8'h07);
    h.op(0, 5'h10, 0);
    chk(h.lastRd, 8'h05);
    reset_n = 0;
    btn = 1;
    cyc(2);
    chk({3'h0, powerStep}, 8'h10);
    chk({7'h00, feBit}, 8'h01);
    reset_n = 1;
    h.op(0, 5'h07, 0);
    chk(h.lastRd, 8'h50);
    end_sim();
  end
endmodule // wsi_wakeup_status_test
`default_nettype wire
